// File: rtl/apz_irq_cfg.sv
// Interrupt mode, light channel select and autozero configuration block
module apz_irq_cfg
    import apz_pkg::*;
(
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 srst,
    // Register port
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic [DATA_W-1:0]    reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [DATA_W-1:0]    reg_rdata,
    // Light engine side
    input  wire logic                 als_irq_status,
    input  wire logic                 irq_pin_routing,
    input  wire logic                 meas_cycle_start,
    output logic      [CHSEL_W-1:0]   light_irq_source_select,
    output logic                      autozero_start,
    // Proximity engine side
    input  wire logic                 prox_sense_on,
    input  apz_prox_in_s              prox_first,
    input  apz_prox_in_s              prox_second,
    // Interrupt pin
    output logic                      irq_out
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    apz_bus_req_s           bus;                // Bundled bus request
    logic [DATA_W-1:0]      mode_reg;           // Interrupt mode config
    apz_light_ch_e          chsel_reg;          // Light channel select
    logic [DATA_W-1:0]      az_reg;             // Autozero interval
    logic [IRQ_W-1:0]       status_reg;         // Sticky event flags
    logic [IRQ_W-1:0]       status_next;        // Next sticky flags
    logic [IRQ_W-1:0]       mask_reg;           // Interrupt mask
    logic [DATA_W-1:0]      rdata_reg;          // Read data register
    logic [DATA_W-1:0]      rdata_next;         // Read data mux
    logic                   irq_reg;            // Pin output register
    logic                   irq_next;           // Next pin value
    logic [DATA_W-1:0]      az_cnt_reg;         // Cycles since autozero
    logic                   az_once_reg;        // One-shot autozero done
    logic                   az_fire;            // Autozero this cycle
    logic                   az_reg_reg;         // Autozero pulse register
    logic                   passthru;           // Light passthrough bit
    logic                   hyst_mode;          // Proximity hysteresis bit
    logic                   wr_mode;            // Write to mode register
    logic                   wr_chsel;           // Write to channel select
    logic                   wr_az;              // Write to autozero config
    logic                   wr_status;          // Write-one-to-clear hit
    logic                   wr_mask;            // Write to mask
    apz_prox_in_s           prox_in [NUM_PROX]; // Channels side by side
    logic [NUM_PROX-1:0]    prox_event;         // Per-channel event pulse
    logic [NUM_PROX-1:0]    prox_near;          // Per-channel near flag
    logic [NUM_PROX-1:0]    prox_armed;         // Per-channel armed flag
    logic [IRQ_W-1:0]       events;             // All event sources

    assign bus       = '{addr: reg_addr, wdata: reg_wdata,
                         wr: reg_wr, rd: reg_rd};
    assign passthru  = mode_reg[BIT_PASSTHRU];
    assign hyst_mode = mode_reg[BIT_HYST];
    assign wr_mode   = bus.wr && (bus.addr == OFS_MODE);
    assign wr_chsel  = bus.wr && (bus.addr == OFS_CHSEL);
    assign wr_az     = bus.wr && (bus.addr == OFS_AZ);
    assign wr_status = bus.wr && (bus.addr == OFS_IRQ_STATUS);
    assign wr_mask   = bus.wr && (bus.addr == OFS_IRQ_MASK);
    assign prox_in[0] = prox_first;
    assign prox_in[1] = prox_second;

    // Outputs straight from flops
    assign reg_rdata               = rdata_reg;
    assign light_irq_source_select = chsel_reg;
    assign autozero_start          = az_reg_reg;
    assign irq_out                 = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers; reserved bits are never stored
    always_ff @(posedge clock) begin
        if (srst) begin
            mode_reg <= RST_MODE;
        end else if (wr_mode) begin
            mode_reg <= bus.wdata & RST_MODE | (bus.wdata & ~RST_MODE &
                        (8'h01 << BIT_PASSTHRU));
        end
    end

    // Light channel selector, all eight codes legal
    always_ff @(posedge clock) begin
        if (srst) begin
            chsel_reg <= LIGHT_CLEAR;
        end else if (wr_chsel) begin
            chsel_reg <= apz_light_ch_e'(bus.wdata[CHSEL_W-1:0]);
        end
    end

    // Autozero interval, reset to the one-shot code
    always_ff @(posedge clock) begin
        if (srst) begin
            az_reg <= RST_AZ;
        end else if (wr_az) begin
            az_reg <= bus.wdata;
        end
    end

    // Interrupt mask
    always_ff @(posedge clock) begin
        if (srst) begin
            mask_reg <= RST_MASK;
        end else if (wr_mask) begin
            mask_reg <= bus.wdata[IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Proximity channels, one tracker each with its own thresholds
    for (genvar ch = 0; ch < NUM_PROX; ch++) begin : g_prox
        apz_prox_hyst u_hyst (
            .clock       (clock),
            .srst        (srst),
            .enable      (prox_sense_on),
            .hyst_mode   (hyst_mode),
            .prox        (prox_in[ch]),
            .event_pulse (prox_event[ch]),
            .near_flag   (prox_near[ch]),
            .armed       (prox_armed[ch])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Autozero scheduling on measurement-cycle boundaries
    always_comb begin
        az_fire = 1'b0;
        if (meas_cycle_start) begin
            if (az_reg == AZ_NEVER) begin
                // Offsets left alone forever
                az_fire = 1'b0;
            end else if (az_reg == AZ_ONCE) begin
                // Only before the first cycle after reset or an interval write
                az_fire = !az_once_reg;
            end else begin
                // Every Nth cycle; N of 1 means every cycle
                az_fire = (az_cnt_reg + AZ_STEP >= az_reg);
            end
        end
    end

    // Cycle counter; a new interval restarts the count
    // A tick in the same cycle as an interval write still uses the old
    // code; software should write the interval between measurements
    always_ff @(posedge clock) begin
        if (srst || wr_az) begin
            az_cnt_reg <= AZ_NEVER;
        end else if (meas_cycle_start) begin
            if (az_fire) begin
                az_cnt_reg <= AZ_NEVER;
            end else if (az_reg != AZ_ONCE) begin
                az_cnt_reg <= az_cnt_reg + AZ_STEP;
            end
        end
    end

    // One-shot memory; rewriting the interval allows another one-shot
    always_ff @(posedge clock) begin
        if (srst || wr_az) begin
            az_once_reg <= 1'b0;
        end else if (az_fire && (az_reg == AZ_ONCE)) begin
            az_once_reg <= 1'b1;
        end
    end

    // Pulse to the light engine that clears its integrator offsets
    always_ff @(posedge clock) begin
        if (srst) begin
            az_reg_reg <= 1'b0;
        end else begin
            az_reg_reg <= az_fire;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky status; a new event beats a same-cycle clear
    assign events = {az_reg_reg, prox_event};
    always_comb begin
        status_next = status_reg;
        if (wr_status) begin
            status_next = status_next & ~bus.wdata[IRQ_W-1:0];
        end
        status_next = status_next | events;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            status_reg <= '0;
        end else begin
            status_reg <= status_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin: light irq passthrough overrides the masked summary while irq_pin_routing is high
    always_comb begin
        if (passthru && irq_pin_routing) begin
            irq_next = als_irq_status;
        end else begin
            irq_next = |(status_reg & mask_reg);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses read zero
    always_comb begin
        rdata_next = '0;
        case (bus.addr)
            OFS_MODE:       rdata_next = mode_reg;
            OFS_CHSEL:      rdata_next[CHSEL_W-1:0] = chsel_reg;
            OFS_AZ:         rdata_next = az_reg;
            OFS_IRQ_STATUS: rdata_next[IRQ_W-1:0] = status_reg;
            OFS_IRQ_MASK:   rdata_next[IRQ_W-1:0] = mask_reg;
            OFS_PROX_STATE: begin
                rdata_next[BIT_NEAR0 +: NUM_PROX]  = prox_near;
                rdata_next[BIT_ARMED0 +: NUM_PROX] = prox_armed;
            end
            default:        rdata_next = '0;
        endcase
    end

    // Data only valid the cycle after a read; held at zero otherwise
    always_ff @(posedge clock) begin
        if (srst) begin
            rdata_reg <= '0;
        end else if (bus.rd) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence s_az_tick(logic [DATA_W-1:0] code);
        meas_cycle_start && (az_reg == code) && !wr_az;
    endsequence

    a_passthru_pin: assert property (
        passthru && irq_pin_routing |=> irq_out == $past(als_irq_status))
        else $error("light irq not passed to pin");
    a_prox_status: assert property (
        prox_event[1] && !prox_event[0] |=> status_reg[1])
        else $error("second proximity event lost");
    a_chsel_write: assert property (
        wr_chsel |=> light_irq_source_select ==
            $past(reg_wdata[CHSEL_W-1:0]))
        else $error("channel select not written");
    a_az_never: assert property (
        s_az_tick(AZ_NEVER) |=> !autozero_start)
        else $error("autozero while disabled");
    a_az_every: assert property (
        s_az_tick(AZ_EVERY) |=> autozero_start)
        else $error("autozero missed at interval one");
    a_az_twice: assert property (
        s_az_tick(8'h02) ##1 (!meas_cycle_start && !wr_az)[*1]
        ##1 s_az_tick(8'h02) |=> ($past(az_reg_reg, 2) != autozero_start))
        else $error("autozero not every second cycle");
    a_az_once: assert property (
        s_az_tick(AZ_ONCE) and !az_once_reg
        |=> autozero_start ##1 az_once_reg)
        else $error("one-shot autozero missing");
    a_az_once_only: assert property (
        az_once_reg && (az_reg == AZ_ONCE) |=> !autozero_start)
        else $error("one-shot autozero repeated");
    a_status_irq: assert property (
        autozero_start && mask_reg[IRQ_AZ] && !passthru
        |=> ##1 irq_out)
        else $error("autozero irq not raised");

    // Events land in status; pin follows the masked summary unless passed
    a_az_status: assert property (
        autozero_start |=> status_reg[IRQ_AZ])
        else $error("autozero status not set");
    a_chsel_hold: assert property (
        !wr_chsel |=> $stable(light_irq_source_select))
        else $error("channel select changed without a write");
    a_pin_summary: assert property (
        !(passthru && irq_pin_routing)
        |=> irq_out == $past(|(status_reg & mask_reg)))
        else $error("pin does not follow masked status");

endmodule

// File: rtl/apz_pkg.sv
// Constants, types and register map of the light/proximity irq block
package apz_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int ADDR_W   = 8;            // Register address width
    localparam int DATA_W   = 8;            // Register data width
    localparam int PROX_W   = 16;           // Proximity result width
    localparam int NUM_PROX = 2;            // Proximity irq channels
    localparam int CHSEL_W  = 3;            // Light channel selector width
    localparam int IRQ_W    = 3;            // Status and mask width

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_MODE       = 8'h9E;
    localparam logic [ADDR_W-1:0] OFS_CHSEL      = 8'h9F;
    localparam logic [ADDR_W-1:0] OFS_AZ         = 8'hA4;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'hB0;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 8'hB1;
    localparam logic [ADDR_W-1:0] OFS_PROX_STATE = 8'hB2;

    ////////////////////////////////////////////////////////////////////////
    // Field positions and reset values
    localparam int BIT_PASSTHRU = 7;        // Light irq passthrough
    localparam int BIT_HYST     = 6;        // Proximity hysteresis mode
    localparam int BIT_NEAR0    = 0;        // Prox state: near flags
    localparam int BIT_ARMED0   = 4;        // Prox state: armed flags
    localparam logic [DATA_W-1:0]  RST_MODE  = 8'h40;
    localparam logic [DATA_W-1:0]  RST_AZ    = 8'hFF;
    localparam logic [IRQ_W-1:0]   RST_MASK  = 3'h0;
    localparam logic [DATA_W-1:0]  AZ_NEVER  = 8'h00;
    localparam logic [DATA_W-1:0]  AZ_EVERY  = 8'h01;
    localparam logic [DATA_W-1:0]  AZ_ONCE   = 8'hFF;
    localparam logic [DATA_W-1:0]  AZ_STEP   = 8'h01;

    // Interrupt status bit positions
    localparam int IRQ_PROX0 = 0;           // Proximity channel 0 event
    localparam int IRQ_AZ    = 2;           // Autozero performed

    ////////////////////////////////////////////////////////////////////////
    // Light channel used for light interrupts and persistence
    typedef enum logic [CHSEL_W-1:0] {
        LIGHT_CLEAR    = 3'h0,
        LIGHT_RED      = 3'h1,
        LIGHT_GREEN    = 3'h2,
        LIGHT_BLUE     = 3'h3,
        LIGHT_LEAKAGE  = 3'h4,
        LIGHT_WIDEBAND = 3'h5,
        LIGHT_IR_FIRST = 3'h6,
        LIGHT_IR_SEC   = 3'h7
    } apz_light_ch_e;

    // Hysteresis tracking state of one proximity channel
    typedef enum logic [1:0] {
        HYS_WAIT = 2'b00,                   // No initial event yet
        HYS_FAR  = 2'b01,                   // Last event was a release
        HYS_NEAR = 2'b10                    // Last event was a detect
    } apz_hyst_e;

    // One proximity result with its own thresholds
    typedef struct packed {
        logic [PROX_W-1:0] result;          // Proximity result
        logic [PROX_W-1:0] low;             // Low threshold
        logic [PROX_W-1:0] high;            // High threshold
        logic              valid;           // New result this cycle
    } apz_prox_in_s;

    // Register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;            // Register address
        logic [DATA_W-1:0] wdata;           // Write data
        logic              wr;              // Write strobe
        logic              rd;              // Read strobe
    } apz_bus_req_s;

endpackage

// File: rtl/apz_prox_hyst.sv
// One proximity channel: hysteresis detect/release or plain window irq
module apz_prox_hyst
    import apz_pkg::*;
(
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         srst,
    // Control
    input  wire logic         enable,
    input  wire logic         hyst_mode,
    // Result and thresholds
    input  apz_prox_in_s      prox,
    // Event and state
    output logic              event_pulse,
    output logic              near_flag,
    output logic              armed
);

    apz_hyst_e state_reg;                   // Tracking state
    apz_hyst_e state_next;                  // Next tracking state
    logic      event_reg;                   // Event pulse register
    logic      event_next;                  // Next event pulse
    logic      below;                       // Result under low threshold
    logic      above;                       // Result over high threshold

    assign below       = prox.result < prox.low;
    assign above       = prox.result > prox.high;
    assign event_pulse = event_reg;
    assign near_flag   = (state_reg == HYS_NEAR);
    assign armed       = (state_reg != HYS_WAIT);

    ////////////////////////////////////////////////////////////////////////
    // Next state and event; with sensing and hysteresis enabled only a fresh result can move anything
    always_comb begin
        state_next = state_reg;
        event_next = 1'b0;
        if (!enable || !hyst_mode) begin
            // Leaving the mode re-arms the initial event
            state_next = HYS_WAIT;
            event_next = enable && prox.valid && (above || below);
        end else if (prox.valid) begin
            case (state_reg)
                HYS_WAIT: begin
                    // First result outside the window fires once
                    if (above) begin
                        state_next = HYS_NEAR;
                        event_next = 1'b1;
                    end else if (below) begin
                        state_next = HYS_FAR;
                        event_next = 1'b1;
                    end
                end
                HYS_FAR: begin
                    // Only an upward crossing is a detect
                    if (above) begin
                        state_next = HYS_NEAR;
                        event_next = 1'b1;
                    end
                end
                HYS_NEAR: begin
                    // Only a downward crossing is a release
                    if (below) begin
                        state_next = HYS_FAR;
                        event_next = 1'b1;
                    end
                end
                default: begin
                    state_next = HYS_WAIT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg <= HYS_WAIT;
        end else begin
            state_reg <= state_next;
        end
    end

    // Event pulse register
    always_ff @(posedge clock) begin
        if (srst) begin
            event_reg <= 1'b0;
        end else begin
            event_reg <= event_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence s_hyst_fresh;
        enable && hyst_mode && prox.valid;
    endsequence

    a_initial_event: assert property (
        s_hyst_fresh and (state_reg == HYS_WAIT) && (above || below)
        |=> event_pulse && armed)
        else $error("initial proximity event missing");
    a_detect_cross: assert property (
        s_hyst_fresh and (state_reg == HYS_FAR) && above
        |=> event_pulse && near_flag)
        else $error("detect crossing not reported");
    a_release_cross: assert property (
        s_hyst_fresh and (state_reg == HYS_NEAR) && below
        |=> event_pulse && !near_flag && armed)
        else $error("release crossing not reported");
    a_no_repeat: assert property (
        s_hyst_fresh and (state_reg == HYS_NEAR) && !below
        |=> !event_pulse && near_flag)
        else $error("event without a crossing");

endmodule

// File: verification/apz_host.sv
// Host model: plain register port master for the irq config block
module apz_host
    import apz_pkg::*;
(
    // Clock
    input  wire logic              clock,
    // Register port toward the block
    output logic [ADDR_W-1:0]      reg_addr,
    output logic [DATA_W-1:0]      reg_wdata,
    output logic                   reg_wr,
    output logic                   reg_rd,
    input  wire logic [DATA_W-1:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    // Bus idle at time zero
    initial begin
        reg_addr  = '0;
        reg_wdata = '0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // One-cycle write strobe, signals move right after an edge
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask
endmodule

// File: verification/tb_top.sv
// Self-checking bench for the light/proximity irq configuration block
module tb_top;
    import apz_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic clock, srst, als, route, tick, pon, irq_out, az_start;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  wdata, rdata, d;
    logic               wr, rd;
    logic [CHSEL_W-1:0] sel;
    apz_prox_in_s       p0, p1;
    int n_errors = 0, cmp_count = 0, cyc = 0;

    apz_host apz_host_i (.clock(clock), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
    apz_irq_cfg apz_irq_cfg_i (.clock(clock), .srst(srst), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .als_irq_status(als), .irq_pin_routing(route),
        .meas_cycle_start(tick), .light_irq_source_select(sel),
        .autozero_start(az_start), .prox_sense_on(pon), .prox_first(p0),
        .prox_second(p1), .irq_out(irq_out));

    ////////////////////////////////////////////////////////////////////////
    // Clock, and a ceiling far above the few hundred cycles used
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        apz_host_i.rd(a, d);
        chk(d, e);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Proximity result on one channel, then status judged and cleared
    task automatic pstep(input int ch, input logic [15:0] r,
                         input logic [7:0] e);
        @(posedge clock);
        if (ch == 0) begin
            p0.result <= r;
            p0.valid  <= 1'b1;
        end else begin
            p1.result <= r;
            p1.valid  <= 1'b1;
        end
        @(posedge clock);
        p0.valid <= 1'b0;
        p1.valid <= 1'b0;
        repeat (4) @(posedge clock);
        apz_host_i.rd(OFS_IRQ_STATUS, d);
        chk(d & 8'h03, e);
        if (e != 8'h00) chk({7'h0, irq_out}, 8'h01);
        apz_host_i.wr(OFS_IRQ_STATUS, 8'h03);
        repeat (3) @(posedge clock);
    endtask

    // One measurement tick; true when an autozero pulse follows it
    task automatic az_tick(input logic e);
        logic [1:0] c;
        c = 2'h0;
        @(posedge clock);
        tick <= 1'b1;
        @(posedge clock);
        tick <= 1'b0;
        #1 c += az_start;
        repeat (2) @(posedge clock) #1 c += az_start;
        chk({7'h0, c != 0}, {7'h0, e});
    endtask

    task automatic az_run(input logic [7:0] v, input int n, input int fire);
        apz_host_i.wr(OFS_AZ, v);
        for (int i = 0; i < n; i++) az_tick(fire[i]);
    endtask

    // Interval two with ticks one idle cycle apart: only the second fires
    task automatic az_pair();
        apz_host_i.wr(OFS_AZ, 8'h02);
        @(posedge clock) tick <= 1'b1;
        @(posedge clock) tick <= 1'b0;
        #1 chk({7'h0, az_start}, 8'h00);
        @(posedge clock) tick <= 1'b1;
        @(posedge clock) tick <= 1'b0;
        #1 chk({7'h0, az_start}, 8'h01);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        srst = 1'b1; als = 0; route = 0; tick = 0; pon = 0;
        p0 = '{result:16'h0096, low:16'h0064, high:16'h00C8, valid:1'b0};
        p1 = p0;
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        // Reset values, unmapped place reads zero and ignores writes
        rchk(OFS_MODE, 8'h40);
        rchk(OFS_CHSEL, 8'h00);
        rchk(OFS_AZ, 8'hFF);
        rchk(OFS_IRQ_MASK, 8'h00);
        apz_host_i.wr(8'h00, 8'hFF);
        rchk(8'h00, 8'h00);
        // Every light channel code reaches the selector
        for (int i = 0; i < 8; i++) begin
            apz_host_i.wr(OFS_CHSEL, 8'(i));
            rchk(OFS_CHSEL, 8'(i));
            chk({5'h0, sel}, 8'(i));
        end
        // Hysteresis on both channels, each with its own state
        apz_host_i.wr(OFS_IRQ_MASK, 8'h03);
        pon <= 1'b1;
        pstep(0, 16'h0096, 8'h00);
        pstep(0, 16'h00FA, 8'h01);
        pstep(0, 16'h00FA, 8'h00);
        pstep(0, 16'h0032, 8'h02 >> 1);
        pstep(0, 16'h0032, 8'h00);
        pstep(0, 16'h00FA, 8'h01);
        pstep(1, 16'h0096, 8'h00);
        pstep(1, 16'h0032, 8'h02);
        rchk(OFS_PROX_STATE, 8'h31);
        // Window mode: every result outside fires, no one-shot arming
        apz_host_i.wr(OFS_MODE, 8'h00);
        pstep(0, 16'h00FA, 8'h01);
        pstep(0, 16'h00FA, 8'h01);
        apz_host_i.wr(OFS_MODE, 8'h40);
        // Autozero: first tick once, never, every, every third, re-armed
        az_tick(1'b1);
        az_tick(1'b0);
        az_run(8'h00, 3, 0);
        az_run(8'h01, 3, 7);
        az_run(8'h03, 6, 36);
        az_run(8'hFF, 2, 1);
        az_pair();
        // Autozero status raises the pin once unmasked, cleared by W1C
        rchk(OFS_IRQ_STATUS, 8'h04);
        apz_host_i.wr(OFS_IRQ_MASK, 8'h04);
        repeat (2) @(posedge clock);
        #1 chk({7'h0, irq_out}, 8'h01);
        apz_host_i.wr(OFS_IRQ_STATUS, 8'h04);
        repeat (3) @(posedge clock);
        #1 chk({7'h0, irq_out}, 8'h00);
        // Autozero with its status unmasked drives the pin
        az_run(8'h01, 1, 1);
        chk({7'h0, irq_out}, 8'h01);
        apz_host_i.wr(OFS_IRQ_STATUS, 8'h04);
        // Light irq passthrough; reserved mode bits read zero
        apz_host_i.wr(OFS_MODE, 8'hFF);
        rchk(OFS_MODE, 8'hC0);
        route <= 1'b1;
        als   <= 1'b1;
        repeat (3) @(posedge clock);
        #1 chk({7'h0, irq_out}, 8'h01);
        @(posedge clock) als <= 1'b0;
        repeat (2) @(posedge clock);
        #1 chk({7'h0, irq_out}, 8'h00);
        @(posedge clock) begin
            als   <= 1'b1;
            route <= 1'b0;
        end
        repeat (3) @(posedge clock);
        #1 chk({7'h0, irq_out}, 8'h00);
        report_and_stop();
    end
endmodule
